// ==== pac_defs.vh ====
// constants shared by the proximity and light configuration register block
`ifndef PAC_DEFS_VH
`define PAC_DEFS_VH

// register offsets
`define PAC_ADDR_WAIT_CFG     8'h0D
`define PAC_ADDR_PULSE_TOTAL  8'h0E
`define PAC_ADDR_ANALOG       8'h0F

// reset values
`define PAC_RST_WAIT_CFG      8'h00
`define PAC_RST_PULSE_TOTAL   8'h00
`define PAC_RST_ANALOG        8'h00

// field positions
`define PAC_BIT_WAIT_EXTEND   1
`define PAC_LED_CUR_HI        7
`define PAC_LED_CUR_LO        6
`define PAC_PROX_PHOTODIODE_SEL_HI         5
`define PAC_PROX_PHOTODIODE_SEL_LO         4
`define PAC_PROX_GAIN_SEL_HI          3
`define PAC_PROX_GAIN_SEL_LO          2
`define PAC_LGAIN_HI          1
`define PAC_LGAIN_LO          0

// timing
`define PAC_CLK_PERIOD_NS     100
`define PAC_WAIT_STEP_NS      2720000
`define PAC_WAIT_STEP_CYC     16'h6A40  // 2.72 ms at 100 ns per cycle
`define PAC_PULSE_RATE_HZ     62500
`define PAC_PULSE_PERIOD_CYC  8'hA0     // 16 us pulse period at 100 ns per cycle
`define PAC_WAIT_LONG_MULT    12'h00C

// drive current in half milliamps and gain multipliers
`define PAC_CUR_100MA         8'hC8
`define PAC_CUR_50MA          8'h64
`define PAC_CUR_25MA          8'h32
`define PAC_CUR_12MA5         8'h19
`define PAC_GAIN_1X           7'h01
`define PAC_GAIN_8X           7'h08
`define PAC_GAIN_16X          7'h10
`define PAC_GAIN_120X         7'h78

`endif

// ==== pac_led_pulser.v ====
// led pulse train generator for one proximity cycle
`timescale 1ns/1ns
`include "pac_defs.vh"

module pac_led_pulser #(
  parameter [7:0] PERIOD_CYC = `PAC_PULSE_PERIOD_CYC
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // control
  input  wire       start,
  input  wire [7:0] pulse_total,
  // status and pin
  output reg        led_pulse_ff,
  output wire       busy,
  output reg        done_ff
);

  // ==========================================================
  // pulse counter and period divider
  // ==========================================================
  reg [7:0] remain_ff;
  reg [7:0] phase_ff;
  reg       run_ff;

  assign busy = run_ff;

  // one pulse per period, high for the first half
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      remain_ff    <= 8'h00;
      phase_ff     <= 8'h00;
      run_ff       <= 1'b0;
      led_pulse_ff <= 1'b0;
      done_ff      <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (!run_ff) begin
        led_pulse_ff <= 1'b0;
        if (start) begin
          if (pulse_total == 8'h00) begin
            done_ff <= 1'b1;               // zero pulses: cycle ends at once
          end else begin
            run_ff       <= 1'b1;
            remain_ff    <= pulse_total;   // exact pulse total
            phase_ff     <= 8'h00;
            led_pulse_ff <= 1'b1;
          end
        end
      end else begin
        if (phase_ff == PERIOD_CYC - 8'h01) begin
          phase_ff <= 8'h00;
          if (remain_ff == 8'h01) begin
            run_ff       <= 1'b0;
            done_ff      <= 1'b1;
            led_pulse_ff <= 1'b0;
          end else begin
            led_pulse_ff <= 1'b1;          // 62.5 kHz pulse rate
          end
          remain_ff <= remain_ff - 8'h01;
        end else begin
          phase_ff <= phase_ff + 8'h01;
          if (phase_ff == (PERIOD_CYC >> 1) - 8'h01) begin
            led_pulse_ff <= 1'b0;
          end
        end
      end
    end
  end

endmodule // pac_led_pulser

// ==== pac_cfg_regs.v ====
// configuration registers with wait timer, proximity pulse sequencing and analog setup decode
//
// Overview of operation
// - wait extend bit set multiplies every programmed wait period by twelve.
// - with proximity enabled, a proximity cycle follows each light cycle that finishes while no pulse train is running.
// - each proximity cycle emits exactly pulse-total led pulses at 62.5 kHz.
// - led current field 7:6 selects 100, 50, 25 or 12.5 mA.
// - light gain field 1:0 selects 1x, 8x, 16x or 120x.
// - wait steps are 2.72 ms; count is two's complement, 0xff is one step.
`timescale 1ns/1ns
`include "pac_defs.vh"

module pac_cfg_regs #(
  parameter [15:0] WAIT_STEP_CYC = `PAC_WAIT_STEP_CYC,
  parameter [7:0]  PULSE_PERIOD  = `PAC_PULSE_PERIOD_CYC
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // register port behind the serial interface
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_ff,
  output reg        reg_rvalid_ff,
  // measurement sequencing
  input  wire       prox_enable,
  input  wire       als_cycle_done,
  input  wire [7:0] wait_period_count,
  input  wire       wait_start,
  output wire       wait_busy,
  output reg        wait_done_ff,
  output wire       prox_busy,
  output wire       prox_done,
  output wire       led_pulse,
  // analog setup
  output reg  [7:0] led_current_half_ma_ff,
  output reg  [1:0] prox_photodiode_sel_ff,
  output reg  [1:0] prox_gain_sel_ff,
  output reg  [6:0] light_gain_mult_ff,
  output wire       wait_extend
);

  // ==========================================================
  // decode functions
  // ==========================================================
  // drive current is coded in half milliamps so that 12.5 mA stays a whole number
  function [7:0] cur_decode;
    input [1:0] code;
    begin
      case (code)
        2'b00:   cur_decode = `PAC_CUR_100MA;
        2'b01:   cur_decode = `PAC_CUR_50MA;
        2'b10:   cur_decode = `PAC_CUR_25MA;
        default: cur_decode = `PAC_CUR_12MA5;
      endcase
    end
  endfunction

  function [6:0] gain_decode;
    input [1:0] code;
    begin
      case (code)
        2'b00:   gain_decode = `PAC_GAIN_1X;
        2'b01:   gain_decode = `PAC_GAIN_8X;
        2'b10:   gain_decode = `PAC_GAIN_16X;
        default: gain_decode = `PAC_GAIN_120X;
      endcase
    end
  endfunction

  // ==========================================================
  // register file
  // ==========================================================
  reg [7:0] wait_scaling_config_ff;
  reg [7:0] prox_pulse_total_reg_ff;
  reg [7:0] analog_setup_ff;

  // host writes land on the next edge; reserved bits are stored as written
  // keeping reserved bits means a read returns exactly what the host wrote
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_scaling_config_ff  <= `PAC_RST_WAIT_CFG;
      prox_pulse_total_reg_ff <= `PAC_RST_PULSE_TOTAL;
      analog_setup_ff         <= `PAC_RST_ANALOG;
    end else if (reg_wr) begin
      case (reg_addr)
        `PAC_ADDR_WAIT_CFG:    wait_scaling_config_ff  <= reg_wdata;
        `PAC_ADDR_PULSE_TOTAL: prox_pulse_total_reg_ff <= reg_wdata;
        `PAC_ADDR_ANALOG:      analog_setup_ff         <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data registered, unmapped offsets read as zero
  // a read in the same cycle as a write returns the old value
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_ff  <= 8'h00;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `PAC_ADDR_WAIT_CFG:    reg_rdata_ff <= wait_scaling_config_ff;
          `PAC_ADDR_PULSE_TOTAL: reg_rdata_ff <= prox_pulse_total_reg_ff;
          `PAC_ADDR_ANALOG:      reg_rdata_ff <= analog_setup_ff;
          default:               reg_rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  assign wait_extend = wait_scaling_config_ff[`PAC_BIT_WAIT_EXTEND];

  // ==========================================================
  // analog setup outputs
  // ==========================================================
  // decoded one cycle behind the register so all outputs change on one edge
  // reserved photodiode and gain codes are passed on unchanged
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      led_current_half_ma_ff <= `PAC_CUR_100MA;
      prox_photodiode_sel_ff <= 2'b00;
      prox_gain_sel_ff       <= 2'b00;
      light_gain_mult_ff     <= `PAC_GAIN_1X;
    end else begin
      led_current_half_ma_ff <= cur_decode(analog_setup_ff[`PAC_LED_CUR_HI:`PAC_LED_CUR_LO]);
      prox_photodiode_sel_ff <= analog_setup_ff[`PAC_PROX_PHOTODIODE_SEL_HI:`PAC_PROX_PHOTODIODE_SEL_LO];  // host keeps 10
      prox_gain_sel_ff       <= analog_setup_ff[`PAC_PROX_GAIN_SEL_HI:`PAC_PROX_GAIN_SEL_LO];    // host keeps 00
      light_gain_mult_ff     <= gain_decode(analog_setup_ff[`PAC_LGAIN_HI:`PAC_LGAIN_LO]);
    end
  end

  // ==========================================================
  // wait timer
  // ==========================================================
  localparam [1:0] W_IDLE = 2'b01;
  localparam [1:0] W_RUN  = 2'b10;

  reg  [1:0]  wstate_ff;
  reg  [1:0]  nxt_wstate;
  reg  [15:0] step_div_ff;
  reg  [11:0] steps_left_ff;
  wire        step_tick;
  wire [8:0]  base_steps;
  wire [11:0] total_steps;

  // two's complement count: 0xff gives one step, 0x00 gives 256
  // 256 steps times twelve needs all twelve bits of the step count
  assign base_steps  = 9'h100 - {1'b0, wait_period_count};
  assign total_steps = wait_extend ? (`PAC_WAIT_LONG_MULT * {3'h0, base_steps})
                                   : {3'h0, base_steps};
  assign step_tick   = (step_div_ff == WAIT_STEP_CYC - 16'h0001);                   // 2.72 ms step
  assign wait_busy   = wstate_ff[1];

  // next state of the wait timer
  // the run ends on the tick that uses up the last step
  always @* begin
    nxt_wstate = wstate_ff;
    case (wstate_ff)
      W_IDLE:  if (wait_start) nxt_wstate = W_RUN;
      W_RUN:   if (step_tick && steps_left_ff == 12'h001) nxt_wstate = W_IDLE;
      default: nxt_wstate = W_IDLE;
    endcase
  end

  // step divider and step count
  // the divider restarts on every tick, so a wait is steps times WAIT_STEP_CYC cycles
  // a start while running is ignored; the next one is taken once idle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wstate_ff     <= W_IDLE;
      step_div_ff   <= 16'h0000;
      steps_left_ff <= 12'h000;
      wait_done_ff  <= 1'b0;
    end else begin
      wstate_ff    <= nxt_wstate;
      wait_done_ff <= 1'b0;
      if (wstate_ff == W_IDLE) begin
        step_div_ff <= 16'h0000;
        if (wait_start) begin
          steps_left_ff <= total_steps;
        end
      end else if (step_tick) begin
        step_div_ff   <= 16'h0000;
        steps_left_ff <= steps_left_ff - 12'h001;
        if (steps_left_ff == 12'h001) begin
          wait_done_ff <= 1'b1;
        end
      end else begin
        step_div_ff <= step_div_ff + 16'h0001;
      end
    end
  end

  // ==========================================================
  // proximity cycle after each light cycle
  // ==========================================================
  wire prox_start;

  // a light cycle ending during a pulse train is dropped, so trains never overlap
  assign prox_start = als_cycle_done & prox_enable & ~prox_busy;

  // a zero pulse total still reports the end of the cycle at once
  pac_led_pulser #(
    .PERIOD_CYC (PULSE_PERIOD)
  ) u_pulser (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .start        (prox_start),
    .pulse_total  (prox_pulse_total_reg_ff),
    .led_pulse_ff (led_pulse),
    .busy         (prox_busy),
    .done_ff      (prox_done)
  );

endmodule // pac_cfg_regs

// ==== pac_cfg_regs_chk.sv ====
// assertion checker for the configuration register block
`timescale 1ns/1ns
module pac_cfg_regs_chk #(
  parameter [15:0] WAIT_STEP_CYC = 16'h0004,
  parameter [7:0]  PULSE_PERIOD  = 8'h08
) (
  // clock and reset
  input wire       clk_sys,
  input wire       rst,
  // register port
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire [7:0] reg_wdata,
  input wire       reg_rd,
  input wire [7:0] reg_rdata_ff,
  // sequencing and setup
  input wire       prox_enable,
  input wire       als_cycle_done,
  input wire       wait_start,
  input wire       wait_busy,
  input wire       wait_done_ff,
  input wire       prox_busy,
  input wire       prox_done,
  input wire       led_pulse,
  input wire [7:0] led_current_half_ma_ff,
  input wire [6:0] light_gain_mult_ff,
  input wire       wait_extend
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // led pulse timing in clock cycles
  localparam int HALF_PULSE = PULSE_PERIOD / 2;
  localparam int FULL_PULSE = PULSE_PERIOD;
  // ==========
  // register port
  reg_readback_a: assert property ((reg_wr && reg_addr == 8'h0E) ##1 !(reg_wr && reg_addr == 8'h0E)
    ##1 (reg_rd && !reg_wr && reg_addr == 8'h0E) |=> reg_rdata_ff == $past(reg_wdata, 3))
    else $error("pulse total read back wrong");
  unmapped_read_a: assert property (reg_rd && (reg_addr < 8'h0D || reg_addr > 8'h0F)
    |=> reg_rdata_ff == 8'h00) else $error("unmapped read not zero");
  // ==========
  // analog setup decode
  led_current_a: assert property (reg_wr && reg_addr == 8'h0F
    |-> ##2 led_current_half_ma_ff == (8'hC8 >> $past(reg_wdata[7:6], 2))) else $error("drive current wrong");
  light_gain_a: assert property (reg_wr && reg_addr == 8'h0F |-> ##2 light_gain_mult_ff ==
    (($past(reg_wdata[1:0], 2) == 2'b11) ? 7'h78 : ($past(reg_wdata[1:0], 2) == 2'b00) ? 7'h01 :
    (7'h04 << $past(reg_wdata[1:0], 2)))) else $error("light gain wrong");
  // ==========
  // wait timer and proximity cycle
  wait_extend_a: assert property (reg_wr && reg_addr == 8'h0D |=> wait_extend == $past(reg_wdata[1]))
    else $error("wait extend not stored");
  wait_run_a: assert property (wait_start && !wait_busy |=> wait_busy)
    else $error("wait did not start");
  wait_end_a: assert property ($fell(wait_busy) |-> wait_done_ff)
    else $error("wait ended without done");
  prox_start_a: assert property (als_cycle_done && prox_enable && !prox_busy |=> prox_busy || prox_done)
    else $error("proximity cycle not started");
  led_in_cycle_a: assert property (led_pulse |-> prox_busy)
    else $error("led pulse outside proximity cycle");
  pulse_high_a: assert property ($rose(led_pulse) |-> ##HALF_PULSE !led_pulse)
    else $error("led pulse high time wrong");
  pulse_period_a: assert property ($rose(led_pulse) |-> ##FULL_PULSE (led_pulse || prox_done))
    else $error("led pulse period wrong");
endmodule // pac_cfg_regs_chk

bind pac_cfg_regs pac_cfg_regs_chk #(.WAIT_STEP_CYC(WAIT_STEP_CYC), .PULSE_PERIOD(PULSE_PERIOD)) chk (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .prox_enable(prox_enable), .als_cycle_done(als_cycle_done),
  .wait_start(wait_start), .wait_busy(wait_busy), .wait_done_ff(wait_done_ff), .prox_busy(prox_busy),
  .prox_done(prox_done), .led_pulse(led_pulse), .led_current_half_ma_ff(led_current_half_ma_ff),
  .light_gain_mult_ff(light_gain_mult_ff), .wait_extend(wait_extend));

// ==== pac_host_model.sv ====
// host model driving the register port
`timescale 1ns/1ns
module pac_host_model (
  // clock
  input wire       clk_sys,
  // register port
  output reg [7:0] reg_addr,
  output reg       reg_wr,
  output reg [7:0] reg_wdata,
  output reg       reg_rd
);
  reg [7:0] exp_q[$];
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // ==========
  // write one byte, reserved fields forced to legal codes, lines scrambled after
  task wr(input [7:0] a, input [7:0] d);
    reg [7:0] v;
    begin
      v = d;
      if (a == 8'h0D) v = d & 8'h02;
      if (a == 8'h0F) v = {d[7:6], 4'h8, d[1:0]};
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~v;
    end
  endtask
  // read one byte and note the expected answer
  task rd(input [7:0] a, input [7:0] e);
    begin
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
    end
  endtask
endmodule // pac_host_model

// ==== pac_cfg_regs_bench.sv ====
// self-checking testbench for the configuration register block
`timescale 1ns/1ns
module pac_cfg_regs_bench;
  reg        clk_sys = 1'b0;
  reg        rst = 1'b1;
  reg        prox_enable = 1'b0;
  reg        als_cycle_done = 1'b0;
  reg  [7:0] wait_period_count = 8'hFF;
  reg        wait_start = 1'b0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_ff, led_current_half_ma_ff;
  wire       reg_wr, reg_rd, reg_rvalid_ff, wait_busy, wait_done_ff, prox_busy, prox_done, led_pulse, wait_extend;
  wire [1:0] prox_photodiode_sel_ff, prox_gain_sel_ff;
  wire [6:0] light_gain_mult_ff;
  integer    miscompares = 0;
  integer    cmp_count = 0;
  integer    i, n, p;
  reg  [7:0] d, e;
  reg        l0;
  // clock at 100 ns
  always #50 clk_sys = ~clk_sys;
  pac_cfg_regs #(.WAIT_STEP_CYC(16'h0004), .PULSE_PERIOD(8'h08)) dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff), .prox_enable(prox_enable),
    .als_cycle_done(als_cycle_done), .wait_period_count(wait_period_count), .wait_start(wait_start),
    .wait_busy(wait_busy), .wait_done_ff(wait_done_ff), .prox_busy(prox_busy), .prox_done(prox_done),
    .led_pulse(led_pulse), .led_current_half_ma_ff(led_current_half_ma_ff),
    .prox_photodiode_sel_ff(prox_photodiode_sel_ff), .prox_gain_sel_ff(prox_gain_sel_ff),
    .light_gain_mult_ff(light_gain_mult_ff), .wait_extend(wait_extend));
  pac_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  // ==========
  // comparison and verdict
  task automatic check(input string name, input [15:0] seen, input [15:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // count edges until done of the wait (0) or proximity (1), and led rises
  task wait_for(input integer sel);
    n = 0;
    p = 0;
    l0 = 1'b0;
    #1;
    while (n < 1000 && ((sel == 0) ? wait_done_ff : prox_done) !== 1'b1) begin
      if (led_pulse === 1'b1 && l0 !== 1'b1) p = p + 1;
      l0 = led_pulse;
      @(posedge clk_sys);
      #1;
      n = n + 1;
    end
    if (n >= 1000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  endtask
  // each read answer against the oldest note
  always @(posedge clk_sys) begin
    if (reg_rvalid_ff === 1'b1) begin
      e = (host.exp_q.size() > 0) ? host.exp_q.pop_front() : ~reg_rdata_ff;
      check("rdata", {8'h00, reg_rdata_ff}, {8'h00, e});
    end
  end
  // ==========
  // main sequence
  initial begin
    d = $urandom(32'hB4BE3D6E);
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 13; i < 16; i = i + 1) host.rd(i[7:0], 8'h00);
    check("led_current", {8'h00, led_current_half_ma_ff}, 16'h00C8);
    check("light_gain", {9'h000, light_gain_mult_ff}, 16'h0001);
    d = $urandom;
    host.wr(8'h0E, d);
    host.rd(8'h0E, d);
    host.rd(8'h10, 8'h00);
    host.rd(8'h0C, 8'h00);
    $display("test reset and readback done");
    for (i = 0; i < 4; i = i + 1) begin
      host.wr(8'h0F, {i[1:0], 4'h5, i[1:0]});
      host.rd(8'h0F, {i[1:0], 4'h8, i[1:0]});
      #1;
      check("led_current", {8'h00, led_current_half_ma_ff}, {8'h00, 32'h193264C8 >> (8 * i)} & 16'h00FF);
      check("light_gain", {9'h000, light_gain_mult_ff}, {8'h00, 32'h78100801 >> (8 * i)} & 16'h00FF);
      check("diode_gain", {12'h000, prox_photodiode_sel_ff, prox_gain_sel_ff}, 16'h0008);
    end
    $display("test analog setup done");
    for (i = 0; i < 3; i = i + 1) begin
      host.wr(8'h0D, (i == 2) ? 8'hFF : 8'h00);
      wait_period_count <= (i == 1) ? 8'hFE : 8'hFF;
      host.rd(8'h0D, (i == 2) ? 8'h02 : 8'h00);
      check("wait_extend", {15'h0000, wait_extend}, (i == 2) ? 16'h0001 : 16'h0000);
      @(posedge clk_sys);
      wait_start <= 1'b1;
      @(posedge clk_sys);
      wait_start <= 1'b0;
      wait_for(0);
      check("wait_cycles", n[15:0], ((i == 1) ? 2 : 1) * ((i == 2) ? 12 : 1) * 4);
    end
    $display("test wait timer done");
    for (i = 0; i < 3; i = i + 1) begin
      d = (i == 0) ? 8'h00 : ($urandom % 5) + 1;
      host.wr(8'h0E, d);
      prox_enable <= (i != 2);
      @(posedge clk_sys);
      als_cycle_done <= 1'b1;
      @(posedge clk_sys);
      als_cycle_done <= 1'b0;
      if (i == 2) begin
        repeat (3) @(posedge clk_sys);
        #1;
        check("prox_idle", {15'h0000, prox_busy}, 16'h0000);
      end else begin
        wait_for(1);
        check("pulses", p[15:0], {8'h00, d});
        check("prox_cycles", n[15:0], d * 8);
      end
    end
    $display("test proximity done");
    print_verdict;
  end
endmodule // pac_cfg_regs_bench
